// [rtl/dms_ctrl.sv]
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dms_defs.svh"

module dms_ctrl
	import dms_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [11:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	input wire logic clk_stable,
	output dms_dram_t dram_r,
	output logic clk_change_ok_r
);

	// ********************************
	// states
	// ********************************
	typedef enum logic [12:0]
	{
		ST_IDLE = 13'h0001,
		ST_MR1 = 13'h0002,
		ST_WMOD = 13'h0004,
		ST_ENTER = 13'h0008,
		ST_WENT = 13'h0010,
		ST_CHANGE = 13'h0020,
		ST_EXIT = 13'h0040,
		ST_WEXIT = 13'h0080,
		ST_LOOPON = 13'h0100,
		ST_LOOPRST = 13'h0200,
		ST_MRS = 13'h0400,
		ST_ZQ = 13'h0800,
		ST_FINAL = 13'h1000
	} dms_st_t;

	dms_st_t st_r;
	logic [31:0] ctrl_r;
	logic [15:0] mr0_r, mr1_r, mr2_r;
	logic [31:0] wait_r [0:7];
	logic [31:0] cnt_r;
	logic [31:0] lock_r;
	logic [1:0] mrs_idx_r;
	logic [1:0] mode_r;
	logic zq_r, odt_en_r, done_r;
	logic wr_go;

	function automatic logic [31:0] dms_init(input logic [2:0] i);
		unique case (i)
			3'd0: dms_init = 32'(`DMS_CYC(`DMS_MOD_PS));
			3'd1: dms_init = 32'(`DMS_CYC(`DMS_MRD_PS));
			3'd2: dms_init = 32'(`DMS_CYC(`DMS_CKSRE_PS));
			3'd3: dms_init = 32'(`DMS_CYC(`DMS_CKSRX_PS));
			3'd4: dms_init = 32'(`DMS_CYC(`DMS_XS_PS));
			3'd5: dms_init = 32'(`DMS_CYC(`DMS_XP_PS));
			3'd6: dms_init = 32'(`DMS_CYC(`DMS_DLLK_PS));
			default: dms_init = 32'(`DMS_CYC(`DMS_ZQOPER_PS));
		endcase
	endfunction

	function automatic logic [2:0] dms_widx(input logic [11:0] a);
		dms_widx = 3'((a - `DMS_WMOD_OFS) >> 2);
	endfunction

	function automatic logic dms_is_wait(input logic [11:0] a);
		dms_is_wait = (a >= `DMS_WMOD_OFS) && (a <= `DMS_WZQ_OFS)
			&& (a[1:0] == 2'b00);
	endfunction

	// ********************************
	// axi4-lite write
	// ********************************
	logic aw_have_r, w_have_r;
	logic [11:0] awaddr_r;
	logic [31:0] wdata_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awaddr_r <= 12'h000;
			wdata_r <= 32'h0;
			s_awready <= 1'b0;
			s_wready <= 1'b0;
			s_bvalid <= 1'b0;
			s_bresp <= 2'b00;
		end
		else
		begin
			s_awready <= !aw_have_r && !s_awready && !s_bvalid;
			s_wready <= !w_have_r && !s_wready && !s_bvalid;
			if (s_awvalid && s_awready)
			begin
				aw_have_r <= 1'b1;
				awaddr_r <= s_awaddr;
				s_awready <= 1'b0;
			end
			if (s_wvalid && s_wready)
			begin
				w_have_r <= 1'b1;
				wdata_r <= s_wdata;
				s_wready <= 1'b0;
			end
			if (aw_have_r && w_have_r && !s_bvalid)
			begin
				s_bvalid <= 1'b1;
				s_bresp <= (awaddr_r <= `DMS_WZQ_OFS && awaddr_r[1:0] == 2'b00)
					? 2'b00 : 2'b10;
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
			end
			if (s_bvalid && s_bready)
				s_bvalid <= 1'b0;
		end
	end

	assign wr_go = aw_have_r && w_have_r && !s_bvalid;

	// ********************************
	// registers
	// ********************************
	// mode, calibration and termination-enable bits are latched at go; mode register and wait writes mid-run still reach the sequence
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_r <= 32'h0;
			mr0_r <= 16'h0000;
			mr1_r <= 16'h0000;
			mr2_r <= 16'h0000;
			for (int i = 0; i < 8; i++)
				wait_r[i] <= dms_init(3'(i));
		end
		else if (wr_go)
		begin
			unique case (awaddr_r)
				`DMS_CTRL_OFS: ctrl_r <= wdata_r;
				`DMS_MR0_OFS: mr0_r <= wdata_r[15:0];
				`DMS_MR1_OFS: mr1_r <= wdata_r[15:0];
				`DMS_MR2_OFS: mr2_r <= wdata_r[15:0];
				default:
					if (dms_is_wait(awaddr_r))
						wait_r[dms_widx(awaddr_r)] <= (wdata_r == 32'h0)
							? 32'h1 : wdata_r; // RULE_23
			endcase
		end
		else if (ctrl_r[`DMS_CTRL_GO])
			ctrl_r[`DMS_CTRL_GO] <= 1'b0;
	end

	// ********************************
	// axi4-lite read
	// ********************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_arready <= 1'b0;
			s_rvalid <= 1'b0;
			s_rdata <= 32'h0;
			s_rresp <= 2'b00;
		end
		else
		begin
			s_arready <= !s_rvalid && !s_arready;
			if (s_arvalid && s_arready)
			begin
				s_arready <= 1'b0;
				s_rvalid <= 1'b1;
				s_rresp <= 2'b00;
				unique case (s_araddr)
					`DMS_CTRL_OFS: s_rdata <= ctrl_r;
					`DMS_STAT_OFS: s_rdata <= {28'h0, st_r != ST_IDLE, done_r,
						clk_change_ok_r, lock_r == 32'h0};
					`DMS_MR0_OFS: s_rdata <= {16'h0, mr0_r};
					`DMS_MR1_OFS: s_rdata <= {16'h0, mr1_r};
					`DMS_MR2_OFS: s_rdata <= {16'h0, mr2_r};
					default:
						if (dms_is_wait(s_araddr))
							s_rdata <= wait_r[dms_widx(s_araddr)];
						else
						begin
							s_rdata <= 32'h0;
							s_rresp <= 2'b10;
						end
				endcase
			end
			if (s_rvalid && s_rready)
				s_rvalid <= 1'b0;
		end
	end

	// ********************************
	// sequencer
	// ********************************
	// mode: 0 loop off, 1 loop on, 2 power-down clock change
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_r <= ST_IDLE;
			cnt_r <= 32'h0;
			mode_r <= 2'b00;
			zq_r <= 1'b0;
			odt_en_r <= 1'b0;
			done_r <= 1'b0;
			mrs_idx_r <= 2'b00;
			clk_change_ok_r <= 1'b0;
			dram_r <= '{cmd: DMS_CMD_NOP, ba: 3'h0, addr: 16'h0000,
				cke: 1'b1, termination_control: 1'b0};
		end
		else
		begin
			dram_r.cmd <= DMS_CMD_NOP;
			if (cnt_r != 32'h0)
				cnt_r <= cnt_r - 32'h1;
			unique case (st_r)
				ST_IDLE:
					if (ctrl_r[`DMS_CTRL_GO])
					begin
						// software guarantees idle banks before go
						mode_r <= ctrl_r[`DMS_CTRL_MODE1:`DMS_CTRL_MODE0]; // RULE_01
						zq_r <= ctrl_r[`DMS_CTRL_ZQ];
						odt_en_r <= ctrl_r[`DMS_CTRL_ODTEN];
						done_r <= 1'b0;
						mrs_idx_r <= 2'd0;
						dram_r.termination_control <= 1'b0; // RULE_08
						st_r <= (ctrl_r[`DMS_CTRL_MODE1:`DMS_CTRL_MODE0] == 2'd0)
							? ST_MR1 : ST_ENTER;
					end
				ST_MR1:
				begin
					dram_r.cmd <= DMS_CMD_MRS;
					dram_r.ba <= 3'h1;
					dram_r.addr <= mr1_r | 16'h0001; // RULE_02
					cnt_r <= wait_r[0];
					st_r <= ST_WMOD;
				end
				ST_WMOD:
					if (cnt_r <= 32'h1)
						st_r <= ST_ENTER; // RULE_03
				ST_ENTER:
				begin
					dram_r.cmd <= (mode_r == 2'd2) ? DMS_CMD_PDE : DMS_CMD_SRE;
					dram_r.cke <= 1'b0;
					dram_r.termination_control <= 1'b0; // RULE_14
					cnt_r <= wait_r[2];
					st_r <= ST_WENT;
				end
				ST_WENT:
					if (cnt_r <= 32'h1)
					begin
						clk_change_ok_r <= 1'b1; // RULE_04 RULE_15 RULE_19
						st_r <= ST_CHANGE;
					end
				ST_CHANGE:
				begin
					// software retunes the clock, then raises clk_stable
					// limitation: new clock range is the clock source's duty
					if (!clk_stable) // RULE_18
						cnt_r <= wait_r[3];
					else if (cnt_r <= 32'h1)
					begin
						clk_change_ok_r <= 1'b0;
						st_r <= ST_EXIT; // RULE_05 RULE_16
					end
				end
				ST_EXIT:
				begin
					dram_r.cmd <= (mode_r == 2'd2) ? DMS_CMD_PDX : DMS_CMD_SRX;
					dram_r.cke <= 1'b1; // RULE_06 RULE_09 RULE_17
					cnt_r <= (mode_r == 2'd2) ? wait_r[5] : wait_r[4];
					st_r <= ST_WEXIT;
				end
				ST_WEXIT:
					if (cnt_r <= 32'h1)
						st_r <= (mode_r == 2'd0) ? ST_MRS : ((mode_r == 2'd1)
							? ST_LOOPON : ST_LOOPRST); // RULE_22
				ST_LOOPON:
					if (cnt_r <= 32'h1)
					begin
						dram_r.cmd <= DMS_CMD_MRS;
						dram_r.ba <= 3'h1;
						dram_r.addr <= mr1_r & 16'hfffe; // RULE_10
						cnt_r <= wait_r[1];
						st_r <= ST_LOOPRST;
					end
				ST_LOOPRST:
					if (cnt_r <= 32'h1)
					begin
						dram_r.cmd <= DMS_CMD_MRS;
						dram_r.ba <= 3'h0;
						dram_r.addr <= mr0_r | 16'h0100; // RULE_11
						cnt_r <= wait_r[1];
						mrs_idx_r <= 2'd0;
						st_r <= ST_MRS;
					end
				ST_MRS:
					if (cnt_r <= 32'h1)
					begin
						// order: mr2, mr1, mr0 then mode-set delay
						dram_r.cmd <= DMS_CMD_MRS;
						unique case (mrs_idx_r)
							2'd0:
							begin
								dram_r.ba <= 3'h2;
								dram_r.addr <= mr2_r;
							end
							2'd1:
							begin
								dram_r.ba <= 3'h1;
								dram_r.addr <= (mode_r == 2'd0) ? (mr1_r | 16'h0001)
									: (mr1_r & 16'hfffe);
							end
							default:
							begin
								dram_r.ba <= 3'h0;
								dram_r.addr <= mr0_r & 16'hfeff;
							end
						endcase
						cnt_r <= (mrs_idx_r == 2'd2) ? wait_r[0] : wait_r[1];
						mrs_idx_r <= mrs_idx_r + 2'd1;
						if (mrs_idx_r == 2'd2)
							st_r <= ST_ZQ; // RULE_07 RULE_12
					end
				ST_ZQ:
					if (cnt_r <= 32'h1)
					begin
						if (zq_r)
						begin
							dram_r.cmd <= DMS_CMD_LONG_CALIBRATION_COMMAND;
							dram_r.addr <= 16'h0400;
							cnt_r <= wait_r[7]; // RULE_13
						end
						st_r <= ST_FINAL;
					end
				ST_FINAL:
					if (cnt_r <= 32'h1 && lock_r <= 32'h1)
					begin
						done_r <= 1'b1; // RULE_13
						st_r <= ST_IDLE;
					end
				default: st_r <= ST_IDLE;
			endcase
		end
	end

	// ********************************
	// lock timer
	// ********************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			lock_r <= 32'h0;
		else if (st_r == ST_LOOPRST && cnt_r <= 32'h1)
			lock_r <= wait_r[6]; // RULE_09 RULE_13
		else if (lock_r != 32'h0)
			lock_r <= lock_r - 32'h1;
	end

endmodule
`default_nettype wire

// [rtl/dms_defs.svh]
// Function
// RULE_01: start a switch only idle, banks precharged, termination off.
// RULE_02: loop off by writing one to bit 0 of mode register one.
// RULE_03: after loop-off write wait mode-set delay, enter self refresh, wait entry clocks.
// RULE_04: request clock change only during self refresh or precharge power-down.
// RULE_05: hold stable new clock for exit clock interval before self-refresh exit.
// RULE_06: loop-off path keeps enable high, termination low until mode-set delay met.
// RULE_07: after exit delay rewrite latencies, optional long calibration, then mode-set delay; code waits the mode-set delay before the optional calibration.
// RULE_08: loop-on path starts idle with termination off before self refresh entry.
// RULE_09: loop-on path keeps enable high, termination low until lock time elapses.
// RULE_10: after exit delay write zero to bit 0 of mode register one.
// RULE_11: after command interval write one to bit 8 of mode register zero.
// RULE_12: after further interval rewrite mode registers; calibration after mode-set delay.
// RULE_13: wait full lock time, plus calibration time if calibration was issued.
// RULE_14: power-down change keeps termination control low.
// RULE_15: power-down change waits entry interval after enable falls, holds both low.
// RULE_16: power-down exit after stable clock, then exit delay, loop reset, latencies.
// RULE_17: during re-lock keep termination low and enable high until lock time.
// RULE_18: new clock frequency must stay within the speed grade range.
// RULE_19: clock period stays stable except during a permitted change.
// RULE_20: device ignores the clock once in self refresh past entry interval.
// RULE_21: with loop off only CAS latency six and write latency six are needed.
// RULE_22: issue only no-operation or deselect during the self-refresh exit delay.
// RULE_23: each wait is a cycle counter loaded from time over clock period, rounded up.
`ifndef DMS_DEFS_SVH
`define DMS_DEFS_SVH

`define DMS_CLK_PS 25000
`define DMS_CYC(ps) (((ps) + `DMS_CLK_PS - 1) / `DMS_CLK_PS)

// default waits in ps
`define DMS_MOD_PS 360000
`define DMS_MRD_PS 100000
`define DMS_CKSRE_PS 250000
`define DMS_CKSRX_PS 250000
`define DMS_XS_PS 1000000
`define DMS_XP_PS 150000
`define DMS_DLLK_PS 12800000
`define DMS_ZQOPER_PS 12800000

// register byte offsets
`define DMS_CTRL_OFS 12'h000
`define DMS_STAT_OFS 12'h004
`define DMS_MR0_OFS 12'h008
`define DMS_MR1_OFS 12'h00c
`define DMS_MR2_OFS 12'h010
`define DMS_WMOD_OFS 12'h014
`define DMS_WMRD_OFS 12'h018
`define DMS_WSRE_OFS 12'h01c
`define DMS_WSRX_OFS 12'h020
`define DMS_WXS_OFS 12'h024
`define DMS_WXP_OFS 12'h028
`define DMS_WDLLK_OFS 12'h02c
`define DMS_WZQ_OFS 12'h030

// control bits
`define DMS_CTRL_GO 0
`define DMS_CTRL_MODE0 1
`define DMS_CTRL_MODE1 2
`define DMS_CTRL_ZQ 3
`define DMS_CTRL_ODTEN 4

`define DMS_MR1_LOOP_OFF_BIT 0
`define DMS_MR0_LOOP_RST_BIT 8
`define DMS_CL_WL_OFF 4'h6

`endif

// [rtl/dms_pkg.sv]
package dms_pkg;
	typedef enum logic [2:0]
	{
		DMS_CMD_NOP = 3'h0,
		DMS_CMD_MRS = 3'h1,
		DMS_CMD_SRE = 3'h2,
		DMS_CMD_SRX = 3'h3,
		DMS_CMD_PDE = 3'h4,
		DMS_CMD_PDX = 3'h5,
		DMS_CMD_LONG_CALIBRATION_COMMAND = 3'h6
	} dms_cmd_t;

	typedef struct packed
	{
		dms_cmd_t cmd;
		logic [2:0] ba;
		logic [15:0] addr;
		logic cke;
		logic termination_control;
	} dms_dram_t;

	typedef struct packed
	{
		logic busy;
		logic done;
		logic clk_change_ok;
		logic loop_locked;
	} dms_stat_t;
endpackage

// [verif/dll_mode_switch_clock_change_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dms_defs.svh"
module dll_mode_switch_clock_change_bench
	import dms_pkg::*;
;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [11:0] s_awaddr = 12'h0, s_araddr = 12'h0;
	logic [31:0] s_wdata = 32'h0, s_rdata, last_q;
	logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0;
	logic s_arvalid = 1'h0, s_rready = 1'h0, clk_stable = 1'h0;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, ok;
	logic [1:0] s_bresp, s_rresp;
	dms_dram_t dram_r;
	logic loop_off_r, bad_r;
	logic [3:0] loop_rst_r;
	int errors = 0, samples_checked = 0;
	logic [33:0] rq[$];
	logic [31:0] mq[$];
	logic [1:0] bq[$];
	dms_ctrl dut (.aclk(aclk), .aresetn(aresetn),
		.s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
		.s_wdata(s_wdata), .s_wstrb(4'hf), .s_wvalid(s_wvalid),
		.s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
		.s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
		.s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
		.s_rvalid(s_rvalid), .s_rready(s_rready), .clk_stable(clk_stable),
		.dram_r(dram_r), .clk_change_ok_r(ok));
	dms_dram_model u_mem (.aclk(aclk), .aresetn(aresetn), .dram(dram_r),
		.loop_off_r(loop_off_r), .loop_rst_r(loop_rst_r), .bad_r(bad_r));
	initial
	begin
		forever #12.5 aclk = ~aclk;
	end
	// ****
	// reporting
	// ****
	task automatic end_of_test();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic hung();
		errors++;
		end_of_test();
	endtask
	task automatic cmp_r(input logic [33:0] e, input logic [31:0] m,
		input logic [33:0] g);
		samples_checked++;
		if ((g & {2'h3, m}) !== e)
		begin
			errors++;
			$display("mismatch read exp %h seen %h", e, g);
		end
	endtask
	task automatic cmp_v(input string s, input logic [3:0] e,
		input logic [3:0] g);
		samples_checked++;
		if (g !== e)
		begin
			errors++;
			$display("mismatch %s exp %h seen %h", s, e, g);
		end
	endtask
	// ****
	// bus master
	// ****
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] r);
		int n;
		@(posedge aclk);
		bq.push_back(r);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'h1;
		s_wvalid <= 1'h1;
		s_bready <= 1'h1;
		for (n = 0; n < 50 && s_bvalid !== 1'h1; n++)
		begin
			@(posedge aclk);
			if (s_awready)
				s_awvalid <= 1'h0;
			if (s_wready)
				s_wvalid <= 1'h0;
		end
		s_bready <= 1'h0;
		if (n == 50)
			hung();
	endtask
	task automatic rd(input logic [11:0] a, input logic [33:0] e,
		input logic [31:0] m);
		int n;
		@(posedge aclk);
		rq.push_back(e);
		mq.push_back(m);
		s_araddr <= a;
		s_arvalid <= 1'h1;
		s_rready <= 1'h1;
		for (n = 0; n < 50 && s_rvalid !== 1'h1; n++)
		begin
			@(posedge aclk);
			if (s_arready)
				s_arvalid <= 1'h0;
		end
		last_q = s_rdata;
		s_rready <= 1'h0;
		if (n == 50)
			hung();
	endtask
	always @(posedge aclk)
	begin
		if (s_bvalid && s_bready && bq.size() > 0)
			cmp_v("bresp", 4'(bq.pop_front()), 4'(s_bresp));
		if (s_rvalid && s_rready && rq.size() > 0)
			cmp_r(rq.pop_front(), mq.pop_front(), {s_rresp, s_rdata});
	end
	// ****
	// scenarios
	// ****
	initial
	begin
		int m;
		int n;
		int k;
		logic [31:0] mr0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		void'($urandom(37422));
		k = 0;
		rd(`DMS_CTRL_OFS, 34'h0, 32'hffffffff);
		rd(`DMS_STAT_OFS, 34'h1, 32'hf);
		rd(`DMS_WMOD_OFS, 34'hf, 32'hffffffff);
		rd(12'h100, 34'h200000000, 32'hffffffff);
		wr(12'h100, 32'h5, 2'h2);
		for (n = 0; n < 8; n++)
			wr(`DMS_WMOD_OFS + 12'(4 * n), 32'h3, 2'h0);
		rd(`DMS_WXS_OFS, 34'h3, 32'hffffffff);
		// reset bit forced on: rewrites must clear it
		mr0 = ($urandom & 32'hffff) | 32'h100;
		wr(`DMS_MR0_OFS, mr0, 2'h0);
		rd(`DMS_MR0_OFS, {2'h0, mr0}, 32'hffff);
		for (m = 0; m < 3; m++)
		begin
			wr(`DMS_MR1_OFS, 32'(m == 0), 2'h0);
			wr(`DMS_CTRL_OFS, 32'h11 | 32'(m << 1) |
				(m == 1 ? 32'h8 : 32'h0), 2'h0);
			for (n = 0; n < 300 && ok !== 1'h1; n++)
				@(posedge aclk);
			if (n == 300)
				hung();
			repeat ($urandom_range(6, 1)) @(posedge aclk);
			clk_stable <= 1'h1;
			last_q = 32'h0;
			for (n = 0; n < 80 && last_q[2] !== 1'h1; n++)
				rd(`DMS_STAT_OFS, 34'h0, 32'h0);
			if (n == 80)
				hung();
			clk_stable <= 1'h0;
			k = k + (m > 0);
			rd(`DMS_STAT_OFS, 34'(m ? 5 : 4), 32'(m ? 15 : 14));
			cmp_v("loop off", 4'(m == 0), 4'(loop_off_r));
			cmp_v("loop reset", 4'(k), loop_rst_r);
			cmp_v("device state", 4'h0, 4'(bad_r));
		end
		end_of_test();
	end
endmodule
bind dms_ctrl dms_ctrl_chk u_chk (.aclk(aclk), .aresetn(aresetn),
	.s_arvalid(s_arvalid), .s_arready(s_arready), .s_rvalid(s_rvalid),
	.s_bvalid(s_bvalid), .s_bready(s_bready), .clk_stable(clk_stable),
	.dram_r(dram_r), .clk_change_ok_r(clk_change_ok_r));
`default_nettype wire

// [verif/dms_ctrl_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module dms_ctrl_chk
	import dms_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_arvalid,
	input wire logic s_arready,
	input wire logic s_rvalid,
	input wire logic s_bvalid,
	input wire logic s_bready,
	input wire logic clk_stable,
	input wire dms_dram_t dram_r,
	input wire logic clk_change_ok_r
);
	// ****
	// sleep entry and exit, termination, mode writes and bus answers
	// ****
	wire logic sr_in = dram_r.cmd == DMS_CMD_SRE || dram_r.cmd == DMS_CMD_PDE;
	wire logic sr_out = dram_r.cmd == DMS_CMD_SRX || dram_r.cmd == DMS_CMD_PDX;
	wire logic mrs = dram_r.cmd == DMS_CMD_MRS || dram_r.cmd == DMS_CMD_LONG_CALIBRATION_COMMAND;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_odt_low: assert property (!dram_r.termination_control)
		else $error("termination control raised");
	a_ok_cke: assert property (clk_change_ok_r |-> !dram_r.cke)
		else $error("clock change offered while awake");
	// bench programs every wait to three cycles
	a_entry_wait: assert property (sr_in |->
		(!dram_r.cke && !clk_change_ok_r)[*3])
		else $error("clock change offered too early");
	a_exit_stable: assert property (sr_out |->
		$past(clk_stable) && $past(clk_stable, 3))
		else $error("wake before clock stable");
	a_exit_cke: assert property (sr_out |-> dram_r.cke)
		else $error("wake without enable high");
	a_exit_quiet: assert property (dram_r.cmd == DMS_CMD_SRX |=>
		(dram_r.cmd == DMS_CMD_NOP)[*2])
		else $error("command during exit delay");
	a_mrs_cke: assert property (mrs |-> dram_r.cke)
		else $error("mode write with enable low");
	a_rd_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
		else $error("read answer late");
	a_b_hold: assert property (s_bvalid && !s_bready |=> s_bvalid)
		else $error("write answer dropped");
	a_b_drop: assert property (s_bvalid && s_bready |=> !s_bvalid)
		else $error("write answer repeated");
endmodule
`default_nettype wire

// [verif/dms_dram_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dms_dram_model
	import dms_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire dms_dram_t dram,
	output logic loop_off_r,
	output logic [3:0] loop_rst_r,
	output logic bad_r
);
	logic asleep_r;
	wire logic mrs = dram.cmd == DMS_CMD_MRS;
	wire logic wake = dram.cmd == DMS_CMD_SRX || dram.cmd == DMS_CMD_PDX;
	// ****
	// loop state
	// ****
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			loop_off_r <= 1'h0;
			loop_rst_r <= 4'h0;
		end
		else if (mrs && dram.ba == 3'h1)
			loop_off_r <= dram.addr[0];
		else if (mrs && dram.ba == 3'h0 && dram.addr[8])
			loop_rst_r <= loop_rst_r + 4'h1;
	end
	// ****
	// sleep: clock is a don't care, only a wake counts
	// ****
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			asleep_r <= 1'h0;
			bad_r <= 1'h0;
		end
		else if (asleep_r)
		begin
			asleep_r <= !wake;
			bad_r <= bad_r | !(wake || dram.cmd == DMS_CMD_NOP);
		end
		else
			asleep_r <= dram.cmd == DMS_CMD_SRE || dram.cmd == DMS_CMD_PDE;
	end
endmodule
`default_nettype wire
